// file: hdl/fic_arb_if.sv
`timescale 1ns/1ps
`default_nettype none
// Carries request, level and choice between controller and arbiter
interface fic_arb_if;
	import fic_pkg::*;
	logic [FIC_NUM_SRC-1:0] req;
	logic [2*FIC_NUM_SRC-1:0] level;
	logic found;
	logic [2:0] src;
	logic [1:0] win_level;
	modport ctrl(output req, output level, input found, input src, input win_level);
	modport arb(input req, input level, output found, output src, output win_level);
endinterface
`default_nettype wire

// file: hdl/fic_arbiter.sv
`timescale 1ns/1ps
`default_nettype none
// Picks best level, then lowest index within it
module fic_arbiter
	import fic_pkg::*;
(
	fic_arb_if.arb bus
);
	always_comb begin
		logic [1:0] lv;
		lv = FIC_LEVEL_NONE;
		bus.found = 1'b0;
		bus.src = 3'h0;
		bus.win_level = FIC_LEVEL_NONE;
		// Level 0 is best; strict less keeps the earlier index on ties [R10] [R11]
		for (int i = 0; i < FIC_NUM_SRC; i++) begin
			lv = bus.level[2*i +: 2];
			if (bus.req[i] && (!bus.found || lv < bus.win_level)) begin
				bus.found = 1'b1;
				bus.src = 3'(i);
				bus.win_level = lv;
			end
		end
	end
endmodule
`default_nettype wire

// file: hdl/fic_controller.sv
// Strobed register access is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// R1 - Each source has its own enable; global enable off suppresses all.
// R2 - Comparator enable routes shared vector to comparator; line-two flag never interrupts.
// R3 - Line-three priority-low bit serves the PWM timer when its enable set.
// R4 - Line-three enable is masked while PWM underflow enable is set.
// R5 - Line-two enable is masked while comparator enable is set.
// R6 - Line two/three flags set on edge, cleared at service, CPU writable.
// R7 - Type 0 level, type 1 edge; high polarity inverts sense.
// R8 - High/low priority bits: 11 level 1 down to 00 level 4.
// R9 - Lower priority never preempts a running higher-priority routine.
// R10 - Higher level serviced first when levels differ in one poll.
// R11 - Equal levels follow fixed polling order; fixed vectors, 2BH unused.
// R12 - External flag cleared on vectoring only when edge-triggered.
// R13 - Timer overflow flags raise interrupts and clear on vectoring.
// R14 - Serial request is OR of receive and transmit done, never cleared.
// R15 - Comparator enabled: comparator flag feeds vector, line-two flag untouched.
// R16 - Comparator disabled: line-two flag cleared on vectoring if its enable set.
// R17 - PWM enabled: underflow flag feeds vector, line-three flag untouched.
// R18 - PWM disabled: line-three flag cleared on vectoring if its enable set.
// R19 - Software flag writes act like hardware updates.
// R20 - Flags sampled once per machine cycle and polled one cycle later.
// R21 - Call blocked by running same/higher level, not last cycle, or RETI/enable write.
// R22 - Blocked requests are not remembered; each poll is fresh.
// R23 - Reserved enable and priority bits ignore writes and read zero.
module fic_controller
	import fic_pkg::*;
#(
	parameter int MCYCLE_CLKS = FIC_MCYCLE_CLKS
) (
	input wire logic clk_sys,
	input wire logic resetn,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// External lines and polarity options
	input wire logic ext_line_two,
	input wire logic ext_line_three,
	input wire logic ext_two_high_polarity,
	input wire logic ext_three_high_polarity,
	// Request flags from the other sources
	input wire logic ext_zero_req,
	input wire logic ext_one_req,
	input wire logic timer_zero_overflow_flag,
	input wire logic timer_one_overflow_flag,
	input wire logic uart_rx_done_flag,
	input wire logic uart_tx_done_flag,
	input wire logic comparator_event_flag,
	input wire logic pwm_underflow_flag,
	input wire logic pwm_underflow_irq_enable,
	input wire logic ext_zero_edge_mode,
	input wire logic ext_one_edge_mode,
	// CPU core handshake
	input wire logic cpu_last_cycle,
	input wire logic cpu_reti,
	input wire logic cpu_ack,
	output logic irq_call,
	output logic [7:0] irq_vector,
	output logic ext_zero_clear,
	output logic ext_one_clear,
	output logic timer_zero_clear,
	output logic timer_one_clear
);
	// The counter is eight bits wide and needs a gap between samples
	if (MCYCLE_CLKS < 2 || MCYCLE_CLKS > 255) begin : g_bad_mcycle
		$error("MCYCLE_CLKS out of range");
	end

	// Index to vector; 2BH slot is skipped
	// The unused slot keeps the shared vectors where software expects them
	function automatic logic [7:0] vec_of(input logic [2:0] s);
		logic [7:0] v;
		v = FIC_VEC_BASE + 8'(s) * FIC_VEC_STEP;
		if (s >= 3'(FIC_SRC_X2)) v = v + FIC_VEC_GAP;
		return v;
	endfunction

	// Pair of priority bits to level, 0 best
	// Inverting makes the smaller number win in the arbiter
	function automatic logic [1:0] level_of(input logic hi, input logic lo);
		return ~{hi, lo}; // [R8]
	endfunction

	// Software-visible registers
	logic [7:0] enable_reg;
	logic [7:0] prio_high_reg;
	logic [7:0] prio_low_reg;
	logic [7:0] aux_reg;
	// Line-two/three state beside the external control bits
	logic x2_flag_reg;
	logic x3_flag_reg;
	logic x2_prio_reg, x3_prio_reg;
	logic x2_en_reg, x3_en_reg;
	logic x2_type_reg, x3_type_reg;
	logic x2_line_reg;
	logic x3_line_reg;
	// Machine-cycle timing and the sampled requests
	logic [7:0] mcyc_reg;
	logic [FIC_NUM_SRC-1:0] sample_reg;
	// One bit per level in service, bit 0 the best
	logic [3:0] active_reg;
	logic block_next_reg;
	// Call in flight
	fic_state_t state_reg;
	logic [2:0] call_src_reg;
	logic [1:0] call_level_reg;

	// Arbiter sees only requests that survived the in-service filter
	fic_arb_if arb_bus();
	fic_arbiter u_arb (
		.bus(arb_bus)
	);

	// Write decodes, one per register
	logic wr_en, wr_pl, wr_ph, wr_xc, wr_aux, sample_tick;
	assign wr_en = reg_wr && reg_addr == FIC_ADDR_IRQ_ENABLE;
	assign wr_pl = reg_wr && reg_addr == FIC_ADDR_PRIO_LOW;
	assign wr_ph = reg_wr && reg_addr == FIC_ADDR_PRIO_HIGH;
	assign wr_xc = reg_wr && reg_addr == FIC_ADDR_EXT_CTRL;
	assign wr_aux = reg_wr && reg_addr == FIC_ADDR_AUX_CTRL;
	assign sample_tick = mcyc_reg == 8'(MCYCLE_CLKS - 1);

	// Shared-slot owners; the timer keeps its own enable, so it comes in as a pin
	logic comp_on, pwm_on;
	assign comp_on = enable_reg[FIC_BIT_COMP];
	assign pwm_on = pwm_underflow_irq_enable;

	// Polarity-corrected line levels: active high internally
	// Edge history resets to the idle level, so a line held active through reset looks like an edge
	logic x2_act, x3_act, x2_edge, x3_edge;
	assign x2_act = ext_line_two ^ ~ext_two_high_polarity; // [R7]
	assign x3_act = ext_line_three ^ ~ext_three_high_polarity; // [R7]
	assign x2_edge = x2_act && !x2_line_reg;
	assign x3_edge = x3_act && !x3_line_reg;

	// Vectoring moment and which flags it clears
	// Clearing at acknowledge, not at the poll, keeps a pending call's flag
	logic vec_now;
	assign vec_now = state_reg == FIC_ST_CALL && cpu_ack;
	logic clr_x2, clr_x3;
	assign clr_x2 = vec_now && call_src_reg == 3'(FIC_SRC_X2) && !comp_on && x2_en_reg && x2_type_reg; // [R12] [R15] [R16]
	assign clr_x3 = vec_now && call_src_reg == 3'(FIC_SRC_X3) && !pwm_on && x3_en_reg && x3_type_reg; // [R12] [R17] [R18]

	// Software-visible registers; reserved bits forced to zero
	// Masking on write keeps reserved bits out of arbitration
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			enable_reg <= FIC_RESET_BYTE;
			prio_high_reg <= FIC_RESET_BYTE;
			prio_low_reg <= FIC_RESET_BYTE;
			aux_reg <= FIC_RESET_BYTE;
		end else begin
			if (wr_en) enable_reg <= reg_wdata & FIC_MASK_IRQ_ENABLE; // [R23]
			if (wr_ph) prio_high_reg <= reg_wdata & FIC_MASK_PRIO_HIGH; // [R23]
			if (wr_pl) prio_low_reg <= reg_wdata & FIC_MASK_PRIO_LOW; // [R23]
			if (wr_aux) aux_reg <= reg_wdata & FIC_MASK_AUX_CTRL;
		end
	end

	// External control fields other than the flags
	// Flag bits are written in the flag process so a pin edge can win
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			{x3_prio_reg, x3_en_reg, x3_type_reg} <= 3'h0;
			{x2_prio_reg, x2_en_reg, x2_type_reg} <= 3'h0;
		end else if (wr_xc) begin
			x3_prio_reg <= reg_wdata[FIC_BIT_X3_PRIO];
			x3_en_reg <= reg_wdata[FIC_BIT_X3_EN];
			x3_type_reg <= reg_wdata[FIC_BIT_X3_TYPE];
			x2_prio_reg <= reg_wdata[FIC_BIT_X2_PRIO];
			x2_en_reg <= reg_wdata[FIC_BIT_X2_EN];
			x2_type_reg <= reg_wdata[FIC_BIT_X2_TYPE];
		end
	end

	// Line-two/three flags: edge or level set wins over any clear
	// Level-type flags follow the line one clock late; writes cannot hold them
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			x2_flag_reg <= 1'b0;
			x3_flag_reg <= 1'b0;
			x2_line_reg <= 1'b0;
			x3_line_reg <= 1'b0;
		end else begin
			x2_line_reg <= x2_act;
			x3_line_reg <= x3_act;
			if (x2_type_reg ? x2_edge : x2_act) x2_flag_reg <= 1'b1; // [R6] [R7]
			else if (!x2_type_reg) x2_flag_reg <= 1'b0; // Level mode follows the line [R12]
			else if (clr_x2) x2_flag_reg <= 1'b0; // [R6]
			else if (wr_xc) x2_flag_reg <= reg_wdata[FIC_BIT_X2_FLAG]; // [R19]
			if (x3_type_reg ? x3_edge : x3_act) x3_flag_reg <= 1'b1; // [R6] [R7]
			else if (!x3_type_reg) x3_flag_reg <= 1'b0; // [R12]
			else if (clr_x3) x3_flag_reg <= 1'b0; // [R6]
			else if (wr_xc) x3_flag_reg <= reg_wdata[FIC_BIT_X3_FLAG]; // [R19]
		end
	end

	// Effective requests per source
	// Shared slots: the owner's enable replaces the line's enable
	logic [FIC_NUM_SRC-1:0] raw_req;
	always_comb begin
		raw_req = '0;
		raw_req[FIC_SRC_X0] = ext_zero_req && enable_reg[FIC_SRC_X0]; // [R1]
		raw_req[FIC_SRC_T0] = timer_zero_overflow_flag && enable_reg[FIC_SRC_T0]; // [R13]
		raw_req[FIC_SRC_X1] = ext_one_req && enable_reg[FIC_SRC_X1];
		raw_req[FIC_SRC_T1] = timer_one_overflow_flag && enable_reg[FIC_SRC_T1]; // [R13]
		raw_req[FIC_SRC_UART] = (uart_rx_done_flag || uart_tx_done_flag) && enable_reg[FIC_SRC_UART]; // [R14]
		raw_req[FIC_SRC_X2] = comp_on ? comparator_event_flag : (x2_flag_reg && x2_en_reg); // [R2] [R5] [R15]
		raw_req[FIC_SRC_X3] = pwm_on ? pwm_underflow_flag : (x3_flag_reg && x3_en_reg); // [R4] [R17]
		if (!enable_reg[FIC_BIT_GLOBAL]) raw_req = '0; // [R1]
	end

	// Priority levels; shared slots take the low bit from the external control
	// Slot five's low bit moves to the low-priority register with the comparator
	always_comb begin
		arb_bus.level = '0;
		for (int i = 0; i < FIC_SRC_X2; i++) begin
			arb_bus.level[2*i +: 2] = level_of(prio_high_reg[i], prio_low_reg[i]); // [R8]
		end
		arb_bus.level[2*FIC_SRC_X2 +: 2] = level_of(prio_high_reg[FIC_SRC_X2+1],
			comp_on ? prio_low_reg[FIC_SRC_X2+1] : x2_prio_reg);
		arb_bus.level[2*FIC_SRC_X3 +: 2] = level_of(prio_high_reg[FIC_SRC_X3+1], x3_prio_reg); // [R3]
	end

	// Only levels strictly better than every running routine may win [R9] [R21]
	// Lowest set bit of the in-service mask is the best level running
	logic [1:0] best_active;
	always_comb begin
		best_active = FIC_LEVEL_NONE;
		for (int l = 3; l >= 0; l--) begin
			if (active_reg[l]) best_active = 2'(l);
		end
	end
	// Any routine in service; requests at or below its level are masked
	logic any_active;
	assign any_active = |active_reg;
	always_comb begin
		arb_bus.req = sample_reg;
		for (int i = 0; i < FIC_NUM_SRC; i++) begin
			if (any_active && arb_bus.level[2*i +: 2] >= best_active) arb_bus.req[i] = 1'b0; // [R9]
		end
	end

	// Machine-cycle counter and the flag sample taken at its end [R20]
	// Limitation: a flag that pulses between two samples is never seen
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			mcyc_reg <= 8'h00;
			sample_reg <= '0;
		end else begin
			mcyc_reg <= sample_tick ? 8'h00 : mcyc_reg + 8'h01;
			if (sample_tick) sample_reg <= raw_req; // Fresh every cycle, nothing kept [R22]
		end
	end

	// RETI or an enable/priority write blocks the next poll [R21]
	// Set beats the sample clear, so a write on the sample edge still blocks
	always_ff @(posedge clk_sys) begin
		if (!resetn) block_next_reg <= 1'b0;
		else if (cpu_reti || wr_en || wr_ph || wr_pl || wr_xc) block_next_reg <= 1'b1;
		else if (sample_tick) block_next_reg <= 1'b0;
	end

	// Poll and call sequencer
	// One call outstanding; polls pause in the call state until acknowledge
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			state_reg <= FIC_ST_IDLE;
			call_src_reg <= 3'h0;
			call_level_reg <= FIC_LEVEL_NONE;
		end else begin
			case (state_reg)
				FIC_ST_IDLE: begin
					if (sample_tick) state_reg <= FIC_ST_POLL; // Poll one cycle after sampling [R20]
				end
				FIC_ST_POLL: begin
					if (sample_tick) begin
						if (arb_bus.found && cpu_last_cycle && !block_next_reg) begin // [R21]
							state_reg <= FIC_ST_CALL;
							call_src_reg <= arb_bus.src;
							call_level_reg <= arb_bus.win_level;
						end
					end
				end
				FIC_ST_CALL: begin
					if (cpu_ack) state_reg <= FIC_ST_POLL;
				end
				default: state_reg <= FIC_ST_IDLE;
			endcase
		end
	end

	// In-service levels; RETI retires the best one when no vectoring falls in the same clock
	// Nesting only ever adds a better level, so the best is the newest
	always_ff @(posedge clk_sys) begin
		if (!resetn) active_reg <= 4'h0;
		else if (vec_now) active_reg[call_level_reg] <= 1'b1;
		else if (cpu_reti && any_active) active_reg[best_active] <= 1'b0;
	end

	// Call outputs and flag-clear pulses to the outside sources
	// Outside sources own their flags and drop them on the pulse
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			irq_call <= 1'b0;
			irq_vector <= FIC_RESET_BYTE;
			ext_zero_clear <= 1'b0;
			ext_one_clear <= 1'b0;
			timer_zero_clear <= 1'b0;
			timer_one_clear <= 1'b0;
		end else begin
			irq_call <= state_reg == FIC_ST_POLL && sample_tick && arb_bus.found && cpu_last_cycle && !block_next_reg;
			if (state_reg == FIC_ST_POLL && sample_tick) irq_vector <= vec_of(arb_bus.src); // [R11]
			if (vec_now) irq_call <= 1'b0;
			else if (state_reg == FIC_ST_CALL) irq_call <= 1'b1;
			ext_zero_clear <= vec_now && call_src_reg == 3'(FIC_SRC_X0) && ext_zero_edge_mode; // [R12]
			ext_one_clear <= vec_now && call_src_reg == 3'(FIC_SRC_X1) && ext_one_edge_mode; // [R12]
			timer_zero_clear <= vec_now && call_src_reg == 3'(FIC_SRC_T0); // [R13]
			timer_one_clear <= vec_now && call_src_reg == 3'(FIC_SRC_T1); // [R13]
		end
	end

	// Read mux, data valid one cycle after the strobe
	// Reads have no side effects; unmapped places read zero
	always_ff @(posedge clk_sys) begin
		if (!resetn) reg_rdata <= FIC_RESET_BYTE;
		else if (reg_rd) begin
			case (reg_addr)
				FIC_ADDR_IRQ_ENABLE: reg_rdata <= enable_reg;
				FIC_ADDR_PRIO_HIGH: reg_rdata <= prio_high_reg;
				FIC_ADDR_PRIO_LOW: reg_rdata <= prio_low_reg;
				FIC_ADDR_EXT_CTRL: reg_rdata <= {x3_prio_reg, x3_en_reg, x3_flag_reg, x3_type_reg,
					x2_prio_reg, x2_en_reg, x2_flag_reg, x2_type_reg};
				FIC_ADDR_AUX_CTRL: reg_rdata <= aux_reg;
				FIC_ADDR_STATUS: reg_rdata <= {1'b0, sample_reg};
				default: reg_rdata <= FIC_RESET_BYTE;
			endcase
		end else reg_rdata <= FIC_RESET_BYTE;
	end
endmodule
`default_nettype wire

// file: hdl/fic_pkg.sv
package fic_pkg;
	// Register offsets on the special-function bus
	localparam logic [7:0] FIC_ADDR_PRIO_HIGH = 8'hB7;
	localparam logic [7:0] FIC_ADDR_PRIO_LOW = 8'hB8;
	localparam logic [7:0] FIC_ADDR_EXT_CTRL = 8'hC0;
	localparam logic [7:0] FIC_ADDR_IRQ_ENABLE = 8'hE8;
	// Own registers for loose bits
	localparam logic [7:0] FIC_ADDR_AUX_CTRL = 8'hF1;
	localparam logic [7:0] FIC_ADDR_STATUS = 8'hF2;
	// Reset values
	localparam logic [7:0] FIC_RESET_BYTE = 8'h00;
	// Writable masks (reserved bits read zero)
	localparam logic [7:0] FIC_MASK_IRQ_ENABLE = 8'hDF;
	localparam logic [7:0] FIC_MASK_PRIO_HIGH = 8'hDF;
	localparam logic [7:0] FIC_MASK_PRIO_LOW = 8'h5F;
	localparam logic [7:0] FIC_MASK_AUX_CTRL = 8'h03;
	// Enable register fields
	localparam int FIC_BIT_GLOBAL = 7;
	localparam int FIC_BIT_COMP = 6;
	// External control fields
	localparam int FIC_BIT_X3_PRIO = 7;
	localparam int FIC_BIT_X3_EN = 6;
	localparam int FIC_BIT_X3_FLAG = 5;
	localparam int FIC_BIT_X3_TYPE = 4;
	localparam int FIC_BIT_X2_PRIO = 3;
	localparam int FIC_BIT_X2_EN = 2;
	localparam int FIC_BIT_X2_FLAG = 1;
	localparam int FIC_BIT_X2_TYPE = 0;
	// Source indices in polling order
	localparam int FIC_NUM_SRC = 7;
	localparam int FIC_SRC_X0 = 0;
	localparam int FIC_SRC_T0 = 1;
	localparam int FIC_SRC_X1 = 2;
	localparam int FIC_SRC_T1 = 3;
	localparam int FIC_SRC_UART = 4;
	localparam int FIC_SRC_X2 = 5;
	localparam int FIC_SRC_X3 = 6;
	// Vector addresses by source
	localparam logic [7:0] FIC_VEC_BASE = 8'h03;
	localparam logic [7:0] FIC_VEC_STEP = 8'h08;
	localparam logic [7:0] FIC_VEC_GAP = 8'h08;
	// Machine cycle length in clocks; sample state is its last clock
	localparam int FIC_MCYCLE_CLKS = 12;
	localparam logic [1:0] FIC_LEVEL_NONE = 2'h3;
	typedef enum logic [2:0] {
		FIC_ST_IDLE = 3'b001,
		FIC_ST_POLL = 3'b010,
		FIC_ST_CALL = 3'b100
	} fic_state_t;
endpackage

// file: test/fic_controller_sva.sv
`timescale 1ns/1ps
`default_nettype none
module fic_controller_sva
	import fic_pkg::*;
#(
	parameter int MCYCLE_CLKS = 12
) (
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic ext_zero_edge_mode,
	input wire logic cpu_last_cycle,
	input wire logic cpu_ack,
	input wire logic irq_call,
	input wire logic [7:0] irq_vector,
	input wire logic ext_zero_clear,
	input wire logic timer_zero_clear,
	input wire logic timer_one_clear
);
	logic global_seen_reg;
	// Mirror of the global enable; a write racing a poll edge would confuse it
	always_ff @(posedge clk_sys) begin
		if (!resetn)
			global_seen_reg <= 1'b0;
		else if (reg_wr && reg_addr == FIC_ADDR_IRQ_ENABLE)
			global_seen_reg <= reg_wdata[FIC_BIT_GLOBAL];
	end
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!resetn);
	a_call_stands: assert property (irq_call && !cpu_ack |=> irq_call && $stable(irq_vector))
		else $error("call or vector moved before acknowledge");
	a_ack_drops: assert property (irq_call && cpu_ack |=> !irq_call)
		else $error("call stayed after acknowledge");
	a_vector_legal: assert property (irq_call |-> irq_vector inside {8'h03, 8'h0B, 8'h13, 8'h1B, 8'h23, 8'h33, 8'h3B})
		else $error("illegal vector");
	a_global_gate: assert property ($rose(irq_call) |-> global_seen_reg)
		else $error("call with global enable off");
	a_last_cycle: assert property ($rose(irq_call) |-> $past(cpu_last_cycle))
		else $error("call not on last cycle");
	a_t0_clear: assert property (cpu_ack && irq_call && irq_vector == 8'h0B |=> timer_zero_clear ##1 !timer_zero_clear)
		else $error("timer zero flag not cleared once");
	a_t1_cause: assert property (timer_one_clear |-> $past(cpu_ack) && $past(irq_vector) == 8'h1B)
		else $error("timer one clear without its call");
	a_x0_edge_only: assert property (ext_zero_clear |-> $past(ext_zero_edge_mode) && $past(irq_vector) == 8'h03)
		else $error("external zero cleared while level type");
	a_rd_reserved: assert property ($past(reg_rd) && $past(reg_addr) == FIC_ADDR_IRQ_ENABLE |-> !reg_rdata[5])
		else $error("reserved enable bit read one");
endmodule
bind fic_controller fic_controller_sva #(.MCYCLE_CLKS(MCYCLE_CLKS)) fic_controller_sva_inst (.clk_sys(clk_sys),
	.resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata), .ext_zero_edge_mode(ext_zero_edge_mode), .cpu_last_cycle(cpu_last_cycle),
	.cpu_ack(cpu_ack), .irq_call(irq_call), .irq_vector(irq_vector), .ext_zero_clear(ext_zero_clear),
	.timer_zero_clear(timer_zero_clear), .timer_one_clear(timer_one_clear));
`default_nettype wire

// file: test/fic_controller_tb.sv
`timescale 1ns/1ps
`default_nettype none
module fic_controller_tb;
	import fic_pkg::*;
	localparam int MC = 4;
	logic clk_sys, resetn, reg_wr, reg_rd, line_two, line_three, pwm_en, x0_edge, tx_done, last_mode, reti_req;
	logic irq_call, cpu_ack, cpu_reti, cpu_last, x0_clr, x1_clr, t0_clr, t1_clr;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, irq_vector, taken_vec, taken_cnt;
	logic [6:0] src;
	logic [3:0] ack_wait;
	logic [7:0] addrs [4] = '{FIC_ADDR_PRIO_HIGH, FIC_ADDR_PRIO_LOW, FIC_ADDR_EXT_CTRL, FIC_ADDR_IRQ_ENABLE};
	logic [7:0] masks [4] = '{8'hDF, 8'h5F, 8'hDD, 8'hDF};
	logic [7:0] vecs [5] = '{8'h03, 8'h0B, 8'h13, 8'h1B, 8'h23};
	int n_errors, compares;
	fic_controller #(.MCYCLE_CLKS(MC)) fic_controller_inst (.clk_sys(clk_sys), .resetn(resetn),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.ext_line_two(line_two), .ext_line_three(line_three), .ext_two_high_polarity(1'b0),
		.ext_three_high_polarity(1'b0), .ext_zero_req(src[0]), .ext_one_req(src[2]),
		.timer_zero_overflow_flag(src[1]), .timer_one_overflow_flag(src[3]), .uart_rx_done_flag(src[4]),
		.uart_tx_done_flag(tx_done), .comparator_event_flag(src[5]), .pwm_underflow_flag(src[6]),
		.pwm_underflow_irq_enable(pwm_en), .ext_zero_edge_mode(x0_edge), .ext_one_edge_mode(1'b1),
		.cpu_last_cycle(cpu_last), .cpu_reti(cpu_reti), .cpu_ack(cpu_ack), .irq_call(irq_call),
		.irq_vector(irq_vector), .ext_zero_clear(x0_clr), .ext_one_clear(x1_clr), .timer_zero_clear(t0_clr),
		.timer_one_clear(t1_clr));
	fic_cpu_model fic_cpu_model_inst (.clk_sys(clk_sys), .resetn(resetn), .irq_call(irq_call),
		.irq_vector(irq_vector), .ack_wait(ack_wait), .reti_req(reti_req), .last_mode(last_mode),
		.cpu_ack(cpu_ack), .cpu_reti(cpu_reti), .cpu_last_cycle(cpu_last), .taken_vec(taken_vec),
		.taken_cnt(taken_cnt));
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	// Flag sources drop their flag on the clear pulse, as the peripherals would
	always @(posedge clk_sys) begin
		if (x0_clr) src[0] <= 1'b0;
		if (t0_clr) src[1] <= 1'b0;
		if (x1_clr) src[2] <= 1'b0;
		if (t1_clr) src[3] <= 1'b0;
	end
	task automatic results();
		if (n_errors == 0 && compares > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk_sys);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		@(negedge clk_sys);
		check(reg_rdata, e);
	endtask
	// Waits for the core model to take a call; a lost call ends the run
	task automatic expect_call(input logic [7:0] v);
		logic [7:0] c0;
		c0 = taken_cnt;
		for (int i = 0; i < 80 && taken_cnt === c0; i++)
			@(negedge clk_sys);
		if (taken_cnt === c0) begin
			check(taken_cnt, c0 + 8'h01);
			results();
		end
		check(taken_vec, v);
	endtask
	task automatic no_call();
		logic [7:0] c0;
		c0 = taken_cnt;
		repeat (MC * 8) @(negedge clk_sys);
		check(taken_cnt, c0);
	endtask
	task automatic reti();
		repeat (2) @(posedge clk_sys);
		reti_req <= 1'b1;
		@(posedge clk_sys);
		reti_req <= 1'b0;
	endtask
	initial begin
		{reg_wr, reg_rd, reg_addr, reg_wdata, src, pwm_en, tx_done, reti_req} = '0;
		{line_two, line_three, x0_edge, last_mode} = 4'hF;
		ack_wait = 4'h0;
		resetn = 1'b0;
		n_errors = 0;
		compares = 0;
		repeat (10) @(posedge clk_sys);
		resetn <= 1'b1;
		@(posedge clk_sys);
		// Reset values, writable masks, then an unmapped place
		foreach (addrs[i]) begin
			rd(addrs[i], 8'h00);
			wr(addrs[i], 8'hFF);
			rd(addrs[i], masks[i]);
			wr(addrs[i], 8'h00);
		end
		rd(8'h10, 8'h00);
		// Source enable alone is not enough without the global enable
		wr(FIC_ADDR_IRQ_ENABLE, 8'h02);
		@(posedge clk_sys) src[1] <= 1'b1;
		no_call();
		wr(FIC_ADDR_IRQ_ENABLE, 8'h82);
		expect_call(8'h0B);
		reti();
		check({7'h00, src[1]}, 8'h00);
		// Five equal-level requests come out in polling order, slow core
		ack_wait <= 4'h5;
		wr(FIC_ADDR_IRQ_ENABLE, 8'h9F);
		@(posedge clk_sys) src <= 7'h1F;
		foreach (vecs[i]) begin
			expect_call(vecs[i]);
			if (i == 4) src[4] <= 1'b0;
			reti();
		end
		ack_wait <= 4'h0;
		// Serial flag is never cleared by the call, so it asks again
		tx_done <= 1'b1;
		expect_call(8'h23);
		reti();
		expect_call(8'h23);
		tx_done <= 1'b0;
		reti();
		// Level 1 timer wins over level 4 external, which must then wait
		wr(FIC_ADDR_PRIO_HIGH, 8'h08);
		wr(FIC_ADDR_PRIO_LOW, 8'h08);
		@(posedge clk_sys) src <= 7'h09;
		expect_call(8'h1B);
		no_call();
		reti();
		expect_call(8'h03);
		reti();
		// Not the last cycle blocks; a flag gone by then is forgotten
		last_mode <= 1'b0;
		@(posedge clk_sys) src[1] <= 1'b1;
		no_call();
		@(posedge clk_sys) src[1] <= 1'b0;
		repeat (MC * 2) @(posedge clk_sys);
		last_mode <= 1'b1;
		no_call();
		// Level-type external zero keeps its flag through the call
		x0_edge <= 1'b0;
		wr(FIC_ADDR_IRQ_ENABLE, 8'h81);
		@(posedge clk_sys) src[0] <= 1'b1;
		expect_call(8'h03);
		reti();
		check({7'h00, src[0]}, 8'h01);
		src[0] <= 1'b0;
		// Comparator owns the shared vector; line-two edge flag is left alone
		wr(FIC_ADDR_EXT_CTRL, 8'h05);
		wr(FIC_ADDR_IRQ_ENABLE, 8'hC0);
		@(posedge clk_sys) line_two <= 1'b0;
		repeat (MC * 3) @(posedge clk_sys);
		line_two <= 1'b1;
		no_call();
		rd(FIC_ADDR_EXT_CTRL, 8'h07);
		@(posedge clk_sys) src[5] <= 1'b1;
		expect_call(8'h33);
		src[5] <= 1'b0;
		reti();
		rd(FIC_ADDR_EXT_CTRL, 8'h07);
		wr(FIC_ADDR_IRQ_ENABLE, 8'h80);
		expect_call(8'h33);
		reti();
		rd(FIC_ADDR_EXT_CTRL, 8'h05);
		// Software-set line-three flag calls and is cleared on vectoring
		wr(FIC_ADDR_EXT_CTRL, 8'h50);
		wr(FIC_ADDR_EXT_CTRL, 8'h70);
		expect_call(8'h3B);
		reti();
		rd(FIC_ADDR_EXT_CTRL, 8'h50);
		// With the timer underflow enabled the line-three flag is masked
		pwm_en <= 1'b1;
		wr(FIC_ADDR_EXT_CTRL, 8'h70);
		no_call();
		@(posedge clk_sys) src[6] <= 1'b1;
		expect_call(8'h3B);
		src[6] <= 1'b0;
		reti();
		rd(FIC_ADDR_EXT_CTRL, 8'h70);
		// Low level on line three requests while it is held
		wr(FIC_ADDR_EXT_CTRL, 8'h40);
		pwm_en <= 1'b0;
		@(posedge clk_sys) line_three <= 1'b0;
		expect_call(8'h3B);
		line_three <= 1'b1;
		reti();
		no_call();
		results();
	end
endmodule
`default_nettype wire

// file: test/fic_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none
module fic_cpu_model (
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic irq_call,
	input wire logic [7:0] irq_vector,
	input wire logic [3:0] ack_wait,
	input wire logic reti_req,
	input wire logic last_mode,
	output logic cpu_ack,
	output logic cpu_reti,
	output logic cpu_last_cycle,
	output logic [7:0] taken_vec,
	output logic [7:0] taken_cnt
);
	logic [3:0] wait_reg;
	// Takes a held call after a chosen delay, acknowledging for one cycle
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			cpu_ack <= 1'b0;
			wait_reg <= 4'h0;
			taken_vec <= 8'h00;
			taken_cnt <= 8'h00;
		end else if (irq_call && !cpu_ack) begin
			if (wait_reg == ack_wait) begin
				cpu_ack <= 1'b1;
				taken_vec <= irq_vector;
				taken_cnt <= taken_cnt + 8'h01;
				wait_reg <= 4'h0;
			end else
				wait_reg <= wait_reg + 4'h1;
		end else
			cpu_ack <= 1'b0;
	end
	// Instruction boundary and return as the bench commands
	always_ff @(posedge clk_sys) begin
		cpu_reti <= resetn && reti_req;
		cpu_last_cycle <= resetn && last_mode;
	end
endmodule
`default_nettype wire
